/* File: hw/sfc_consts.svh */
/*
  opcodes, status bit positions, reset values, register offsets and timing counts
  assumes: included by bare name from the serial flash command design files
*/
`ifndef SFC_CONSTS_SVH
`define SFC_CONSTS_SVH
`define SFC_OP_WRITE_ENABLE      8'h06
`define SFC_OP_WRITE_DISABLE     8'h04
`define SFC_OP_ARM_STATUS_WRITE  8'h50
`define SFC_OP_STATUS_WRITE      8'h01
`define SFC_OP_ID_READ           8'h9F
`define SFC_OP_LEGACY_ID_A       8'h90
`define SFC_OP_LEGACY_ID_B       8'hAB
`define SFC_OP_AUTO_INC          8'hAD
`define SFC_ST_PERMIT            1
`define SFC_ST_AUTO_INC          6
`define SFC_ST_LOCK              7
`define SFC_ST_RESET             8'h3C
`define SFC_ST_WRITABLE          8'hBC
`define SFC_REG_TXDATA           8'h00
`define SFC_REG_CMD              8'h04
`define SFC_REG_STATUS           8'h08
`define SFC_REG_RXDATA           8'h0C
`define SFC_REG_CTRL             8'h10
`define SFC_CMD_TXN_LSB          0
`define SFC_CMD_RXN_LSB          4
`define SFC_HCLK_NS              4
`define SFC_SCK_HALF_NS          16
`define SFC_SCK_HALF_CYC         ((`SFC_SCK_HALF_NS + `SFC_HCLK_NS - 1) / `SFC_HCLK_NS)
`endif

/* File: hw/sfc_pkg.sv */
/*
  types shared by both ends of the serial flash command link
  assumes: nothing beyond a SystemVerilog compiler
*/
package sfc_pkg;
	typedef logic [7:0]  sfc_status_type;
	typedef logic [31:0] sfc_word_type;
	typedef enum logic [2:0] {SFC_IDLE, SFC_LOW, SFC_HIGH, SFC_END, SFC_GAP} sfc_host_state_type;
endpackage

/* File: hw/sfc_link_if.sv */
/*
  serial link between host controller and flash command logic
  assumes: serial output is pulled high while the device releases it
*/
`timescale 1ns/10ps
interface sfc_link_if;
	logic sck;
	logic cs_n;
	logic si;
	logic so;
	logic so_oe_n;
	logic wp_n;
	logic so_line;

	assign so_line = so_oe_n ? 1'b1 : so;

	modport dev (input sck, input cs_n, input si, input wp_n, output so, output so_oe_n);
	modport host (output sck, output cs_n, output si, output wp_n, input so_line);
endinterface // sfc_link_if

/* File: hw/sfc_dev.sv */
/*
  flash command logic: write permit, write disable, protected status write, id readout
  assumes: sck is the link clock, cs_n rising ends a frame, sck stands still while cs_n is high
*/
// How it works
// - write enable sets the write permit latch
// - no program starts while permit latch clear
// - status write clears permit latch at end
// - single-byte commands execute on chip-select rise
// - write disable clears permit and auto-increment
// - write disable also ends a running auto-increment program
// - arm command must directly precede status write
// - host frames the arm command with chip-select
// - status write changes only protect and lock
// - locked and protect pin low: write ignored
// - lock takes data bit 7 on any applied status write, pin high or low
// - lock checked at chip-select rise
// - id opcode returns maker, type, capacity bytes
// - chip-select rise stops id output, releases line
// - two legacy opcodes plus address enter legacy id
// - legacy id alternates maker and device bytes
// - write disable opcode is one byte
`timescale 1ns/10ps
`include "sfc_consts.svh"
module sfc_dev #(
	parameter logic [7:0] MFR_ID  = 8'h5A, // arbitrary
	parameter logic [7:0] TYPE_ID = 8'h31, // arbitrary
	parameter logic [7:0] CAP_ID  = 8'h42, // arbitrary
	parameter logic [7:0] DEV_ID  = 8'h6C  // arbitrary
) (
	sfc_link_if.dev              link,
	input  wire logic            rst_n,
	output sfc_pkg::sfc_status_type status
);
	import sfc_pkg::*;

	function automatic logic is_legacy(input logic [7:0] op);
		is_legacy = (op == `SFC_OP_LEGACY_ID_A) || (op == `SFC_OP_LEGACY_ID_B);
	endfunction

	function automatic logic [7:0] id_byte(input logic [1:0] sel);
		case (sel)
			2'd0:    id_byte = MFR_ID;
			2'd1:    id_byte = TYPE_ID;
			2'd2:    id_byte = CAP_ID;
			default: id_byte = DEV_ID;
		endcase
	endfunction

	// link clock domain, rising edge
	logic           wp_s1_q;
	logic           wp_s2_q;
	logic           seen_q;
	logic [2:0]     bit_q;
	logic [2:0]     byte_q;
	logic [7:0]     sh_q;
	logic [7:0]     op_q;
	logic [7:0]     dat_q;
	logic           tx_load_q;
	logic           tx_on_q;
	logic [7:0]     tx_byte_q;
	logic [1:0]     id_sel_q;
	// link clock domain, falling edge
	logic [7:0]     tx_sh_q;
	logic           so_q;
	logic           so_oe_n_q;
	// chip-select rise domain
	logic           end_tgl_q;
	logic           arm_q;
	sfc_status_type stat_q;

	// frame start seen as toggle mismatch; end_tgl_q is stable long before the first sck edge
	wire            new_frame   = end_tgl_q ^ seen_q;
	wire  [2:0]     bit_eff     = new_frame ? 3'd0 : bit_q;
	wire  [2:0]     byte_eff    = new_frame ? 3'd0 : byte_q;
	wire            byte_done   = (bit_eff == 3'd7);
	wire  [7:0]     sh_d        = {sh_q[6:0], link.si};
	wire            jedec_start = byte_done && (byte_eff == 3'd0) && (sh_d == `SFC_OP_ID_READ);
	wire            jedec_next  = byte_done && (byte_eff != 3'd0) && (op_q == `SFC_OP_ID_READ);
	wire            leg_start   = byte_done && (byte_eff == 3'd3) && is_legacy(op_q);
	wire            leg_next    = byte_done && (byte_eff >= 3'd4) && is_legacy(op_q);
	wire            tx_load     = jedec_start || jedec_next || leg_start || leg_next;
	wire            leg_mode    = leg_start || leg_next;
	wire  [1:0]     sel_now     = jedec_start ? 2'd0 : (leg_start ? {sh_d[0], sh_d[0]} : id_sel_q);
	wire  [1:0]     sel_jedec   = (sel_now == 2'd2) ? 2'd0 : 2'(sel_now + 2'd1);
	wire  [1:0]     sel_leg     = (sel_now == 2'd0) ? 2'd3 : 2'd0;
	wire  [1:0]     sel_after   = leg_mode ? sel_leg : sel_jedec;
	wire            byte_sat    = (byte_eff == 3'd7);

	always_ff @(posedge link.sck or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wp_s1_q <= 1'b1;
			wp_s2_q <= 1'b1;
		end
		else
		begin
			wp_s1_q <= link.wp_n;
			wp_s2_q <= wp_s1_q;
		end
	end

	always_ff @(posedge link.sck or negedge rst_n)
	begin
		if (!rst_n)
		begin
			seen_q <= 1'b0;
			bit_q  <= 3'd0;
			byte_q <= 3'd0;
			sh_q   <= 8'h00;
		end
		else
		begin
			seen_q <= end_tgl_q;
			bit_q  <= 3'(bit_eff + 3'd1);
			sh_q   <= sh_d;
			byte_q <= (byte_done && !byte_sat) ? 3'(byte_eff + 3'd1) : byte_eff;
		end
	end

	always_ff @(posedge link.sck or negedge rst_n)
	begin
		if (!rst_n)
		begin
			op_q  <= 8'h00;
			dat_q <= 8'h00;
		end
		else if (byte_done && (byte_eff == 3'd0))
			op_q <= sh_d;
		else if (byte_done && (byte_eff == 3'd1))
			dat_q <= sh_d;
	end

	always_ff @(posedge link.sck or negedge rst_n)
	begin
		if (!rst_n)
		begin
			tx_load_q <= 1'b0;
			tx_on_q   <= 1'b0;
			tx_byte_q <= 8'h00;
			id_sel_q  <= 2'd0;
		end
		else
		begin
			tx_load_q <= tx_load;
			tx_on_q   <= (tx_on_q && !new_frame) || tx_load;
			if (tx_load)
			begin
				tx_byte_q <= id_byte(sel_now);
				id_sel_q  <= sel_after;
			end
		end
	end

	// output bits change on the falling edge, msb first
	always_ff @(negedge link.sck or negedge rst_n)
	begin
		if (!rst_n)
		begin
			tx_sh_q <= 8'h00;
			so_q    <= 1'b0;
		end
		else if (tx_load_q)
		begin
			so_q    <= tx_byte_q[7];
			tx_sh_q <= {tx_byte_q[6:0], 1'b0};
		end
		else
		begin
			so_q    <= tx_sh_q[7];
			tx_sh_q <= {tx_sh_q[6:0], 1'b0};
		end
	end

	// released at once when chip-select rises
	always_ff @(negedge link.sck or posedge link.cs_n or negedge rst_n)
	begin
		if (!rst_n)
			so_oe_n_q <= 1'b1;
		else if (link.cs_n)
			so_oe_n_q <= 1'b1;
		else
			so_oe_n_q <= !(tx_on_q && !new_frame);
	end

	// command execution at the end of a frame with whole bytes
	wire            cmd_ok     = !new_frame && (bit_q == 3'd0);
	wire            single     = cmd_ok && (byte_q == 3'd1);
	wire            do_write_enable_cmd    = single && (op_q == `SFC_OP_WRITE_ENABLE);
	wire            do_write_disable_cmd    = single && (op_q == `SFC_OP_WRITE_DISABLE);
	wire            do_arm     = single && (op_q == `SFC_OP_ARM_STATUS_WRITE);
	wire            do_status_write_cmd    = cmd_ok && (byte_q == 3'd2) && (op_q == `SFC_OP_STATUS_WRITE);
	wire            do_aai     = cmd_ok && (byte_q == 3'd6) && (op_q == `SFC_OP_AUTO_INC);
	wire            permit     = stat_q[`SFC_ST_PERMIT];
	wire            status_write_cmd_auth  = arm_q || permit;
	wire            status_write_cmd_lock  = !wp_s2_q && stat_q[`SFC_ST_LOCK];
	wire            status_write_cmd_apply = do_status_write_cmd && status_write_cmd_auth && !status_write_cmd_lock;
	wire  [7:0]     wr_mask    = `SFC_ST_WRITABLE;
	wire  [7:0]     stat_wr    = (stat_q & ~wr_mask) | (dat_q & wr_mask);
	wire  [7:0]     stat_base  = status_write_cmd_apply ? stat_wr : stat_q;
	wire            permit_d   = do_write_enable_cmd ? 1'b1 : ((do_write_disable_cmd || do_status_write_cmd) ? 1'b0 : permit);
	wire            aai_d      = do_write_disable_cmd ? 1'b0 : ((do_aai && permit) ? 1'b1 : stat_q[`SFC_ST_AUTO_INC]);

	always_ff @(posedge link.cs_n or negedge rst_n)
	begin
		if (!rst_n)
		begin
			end_tgl_q <= 1'b0;
			arm_q     <= 1'b0;
			stat_q    <= `SFC_ST_RESET;
		end
		else if (!new_frame)
		begin
			end_tgl_q <= ~end_tgl_q;
			arm_q     <= do_arm;
			stat_q    <= {stat_base[7], aai_d, stat_base[5:2], permit_d, stat_base[0]};
		end
	end

	assign link.so      = so_q;
	assign link.so_oe_n = so_oe_n_q;
	assign status       = stat_q;

endmodule // sfc_dev

/* File: hw/sfc_host.sv */
/*
  host controller: AHB-Lite register slave that runs one chip-select frame per command
  assumes: single whole-word transfers; the link clock is divided down from hclk and driven out
*/
// The AHB-Lite interface to the registers and the address map were decided locally.
`timescale 1ns/10ps
`include "sfc_consts.svh"
module sfc_host #(
	parameter int HALF_CYC = `SFC_SCK_HALF_CYC
) (
	input  wire logic            hclk,
	input  wire logic            hresetn,
	input  wire logic            hsel,
	input  wire logic [31:0]     haddr,
	input  wire logic [1:0]      htrans,
	input  wire logic            hwrite,
	input  wire logic [2:0]      hsize,
	input  wire sfc_pkg::sfc_word_type hwdata,
	input  wire logic            hready,
	output logic                 hreadyout,
	output sfc_pkg::sfc_word_type hrdata,
	output logic                 hresp,
	sfc_link_if.host             link
);
	import sfc_pkg::*;

	logic               pend_q;
	logic               wr_q;
	logic [7:0]         a_q;
	logic               hreadyout_q;
	sfc_word_type       hrdata_q;
	sfc_word_type       tx_q;
	logic [2:0]         txn_q;
	logic [2:0]         rxn_q;
	logic               wp_q;
	sfc_word_type       rx_q;
	sfc_word_type       txsh_q;
	sfc_host_state_type st_q;
	logic [7:0]         div_q;
	logic [6:0]         bit_q;
	logic               sck_q;
	logic               cs_n_q;
	logic               si_q;
	logic               so_s1_q;
	logic               so_s2_q;

	wire                take      = hsel && htrans[1] && hready;
	wire                wr_now    = pend_q && wr_q;
	wire                idle      = (st_q == SFC_IDLE);
	wire  [2:0]         txn_w     = hwdata[`SFC_CMD_TXN_LSB +: 3];
	wire  [2:0]         rxn_w     = hwdata[`SFC_CMD_RXN_LSB +: 3];
	wire                start     = wr_now && (a_q == `SFC_REG_CMD) && idle && (txn_w != 3'd0);
	wire  [6:0]         tx_bits   = {1'b0, txn_q, 3'b000};
	wire  [6:0]         tot_bits  = {({1'b0, txn_q} + {1'b0, rxn_q}), 3'b000};
	wire                half_done = (div_q == 8'(HALF_CYC - 1));
	wire                last_bit  = (bit_q == 7'(tot_bits - 7'd1));
	wire                sample_rx = (bit_q >= tx_bits);
	wire                hsize_ok  = (hsize == 3'd2);

	function automatic sfc_word_type rd_mux(input logic [7:0] a);
		case (a)
			`SFC_REG_TXDATA: rd_mux = tx_q;
			`SFC_REG_CMD:    rd_mux = {25'd0, rxn_q, 1'b0, txn_q};
			`SFC_REG_STATUS: rd_mux = {31'd0, !idle};
			`SFC_REG_RXDATA: rd_mux = rx_q;
			`SFC_REG_CTRL:   rd_mux = {31'd0, wp_q};
			default:         rd_mux = 32'h0000_0000;
		endcase
	endfunction

	// one wait state on every transfer
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			pend_q      <= 1'b0;
			wr_q        <= 1'b0;
			a_q         <= 8'h00;
			hreadyout_q <= 1'b1;
			hrdata_q    <= 32'h0000_0000;
		end
		else if (take)
		begin
			pend_q      <= 1'b1;
			wr_q        <= hwrite && hsize_ok;
			a_q         <= haddr[7:0];
			hreadyout_q <= 1'b0;
		end
		else if (pend_q)
		begin
			pend_q      <= 1'b0;
			hreadyout_q <= 1'b1;
			hrdata_q    <= rd_mux(a_q);
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			tx_q  <= 32'h0000_0000;
			txn_q <= 3'd1;
			rxn_q <= 3'd0;
			wp_q  <= 1'b1;
		end
		else if (wr_now && idle)
		begin
			if (a_q == `SFC_REG_TXDATA)
				tx_q <= hwdata;
			if (start)
			begin
				txn_q <= (txn_w > 3'd4) ? 3'd4 : txn_w;
				rxn_q <= (rxn_w > 3'd4) ? 3'd4 : rxn_w;
			end
			if (a_q == `SFC_REG_CTRL)
				wp_q <= hwdata[0];
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			so_s1_q <= 1'b1;
			so_s2_q <= 1'b1;
		end
		else
		begin
			so_s1_q <= link.so_line;
			so_s2_q <= so_s1_q;
		end
	end

	// mode 0 framing, msb first; bit driven while sck low, read on its rise
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			st_q   <= SFC_IDLE;
			div_q  <= 8'd0;
			bit_q  <= 7'd0;
			sck_q  <= 1'b0;
			cs_n_q <= 1'b1;
			si_q   <= 1'b0;
			txsh_q <= 32'h0000_0000;
			rx_q   <= 32'h0000_0000;
		end
		else
		begin
			div_q <= (idle || half_done) ? 8'd0 : 8'(div_q + 8'd1);
			case (st_q)
				SFC_IDLE:
					if (start)
					begin
						cs_n_q <= 1'b0;
						si_q   <= tx_q[31];
						txsh_q <= {tx_q[30:0], 1'b0};
						bit_q  <= 7'd0;
						rx_q   <= 32'h0000_0000;
						st_q   <= SFC_LOW;
					end
				SFC_LOW:
					if (half_done)
					begin
						sck_q <= 1'b1;
						if (sample_rx)
							rx_q <= {rx_q[30:0], so_s2_q};
						st_q <= SFC_HIGH;
					end
				SFC_HIGH:
					if (half_done)
					begin
						sck_q <= 1'b0;
						if (last_bit)
							st_q <= SFC_END;
						else
						begin
							bit_q  <= 7'(bit_q + 7'd1);
							si_q   <= txsh_q[31];
							txsh_q <= {txsh_q[30:0], 1'b0};
							st_q   <= SFC_LOW;
						end
					end
				SFC_END:
					if (half_done)
					begin
						cs_n_q <= 1'b1;
						st_q   <= SFC_GAP;
					end
				SFC_GAP:
					if (half_done)
						st_q <= SFC_IDLE;
				default:
					st_q <= SFC_IDLE;
			endcase
		end
	end

	assign hreadyout = hreadyout_q;
	assign hrdata    = hrdata_q;
	assign hresp     = 1'b0;
	assign link.sck  = sck_q;
	assign link.cs_n = cs_n_q;
	assign link.si   = si_q;
	assign link.wp_n = wp_q;

endmodule // sfc_host

/* File: bench/sfc_link_asserts.sv */
/*
  link checker: framing, status update and id readout properties
  assumes: placed beside the link interface; the host makes sck, mode 0
*/
`timescale 1ns/10ps
module sfc_link_asserts #(
	parameter logic [7:0] MFR_ID = 8'h5A // arbitrary
) (
	input wire logic                    hclk,
	input wire logic                    hresetn,
	input wire logic                    rst_n,
	input wire logic                    sck,
	input wire logic                    cs_n,
	input wire logic                    si,
	input wire logic                    so_oe_n,
	input wire logic                    wp_n,
	input wire logic                    so_line,
	input wire sfc_pkg::sfc_status_type status
);
	import sfc_pkg::*;
	logic [7:0] sh_q;
	logic [7:0] op_q;
	logic [7:0] nb_q;
	logic [7:0] fr_op_q;
	logic [7:0] fr_n_q;

	// bits seen in the current frame, saturating
	always_ff @(posedge sck or posedge cs_n)
	begin
		if (cs_n)
			nb_q <= 8'h00;
		else if (nb_q != 8'hFF)
			nb_q <= nb_q + 8'h01;
	end

	always_ff @(posedge sck)
	begin
		sh_q <= {sh_q[6:0], si};
		if (nb_q == 8'h07)
			op_q <= {sh_q[6:0], si};
	end

	// opcode and length of the frame just ended
	always_ff @(posedge cs_n)
	begin
		fr_op_q <= op_q;
		fr_n_q <= nb_q;
	end

	a_deselect_release: assert property (@(posedge hclk) disable iff (!hresetn)
		cs_n |-> so_oe_n && so_line) else $error("serial output driven while deselected");
	a_sck_idle_low: assert property (@(posedge hclk) disable iff (!hresetn)
		$rose(cs_n) |-> (cs_n && !sck) [*4]) else $error("clock not idle low between frames");
	a_frame_status_stable: assert property (@(posedge hclk) disable iff (!rst_n)
		!cs_n && !$past(cs_n) |-> $stable(status)) else $error("status changed inside a frame");
	a_permit_source: assert property (@(posedge hclk) disable iff (!rst_n)
		$rose(status[1]) |-> cs_n && fr_op_q == 8'h06 && fr_n_q == 8'h08)
		else $error("permit latch set without enable frame");
	a_enable_sets: assert property (@(posedge hclk) disable iff (!rst_n)
		$rose(cs_n) && fr_op_q == 8'h06 && fr_n_q == 8'h08 |-> status[1])
		else $error("enable frame left permit latch clear");
	a_disable_clears: assert property (@(posedge hclk) disable iff (!rst_n)
		$rose(cs_n) && fr_op_q == 8'h04 && fr_n_q == 8'h08 |-> !status[1] && !status[6])
		else $error("disable frame left permit or auto bit set");
	a_swrite_clears: assert property (@(posedge hclk) disable iff (!rst_n)
		$rose(cs_n) && fr_op_q == 8'h01 && fr_n_q == 8'h10 |-> !status[1] && !status[0]
		&& status[6] == $past(status[6])) else $error("status write mishandled fixed bits");
	a_lock_ignores: assert property (@(posedge hclk) disable iff (!rst_n)
		$rose(cs_n) && fr_op_q == 8'h01 && !wp_n && $past(status[7])
		|-> status[7:2] == $past(status[7:2])) else $error("locked status register changed");
	a_id_maker_first: assert property (@(posedge sck) disable iff (!rst_n)
		nb_q == 8'h08 && op_q == 8'h9F |-> !so_oe_n && so_line == MFR_ID[7])
		else $error("id readout does not start with maker code");
endmodule // sfc_link_asserts

/* File: bench/test_spi_flash_write_enable_cmd_status_id_cmds.sv */
/*
  testbench: host and device joined by the link, driven over the register bus
  assumes: default host clock divider, device id parameters set here
*/
`timescale 1ns/10ps
module test_spi_flash_write_enable_cmd_status_id_cmds;
	import sfc_pkg::*;
	localparam logic [7:0] MFR = 8'h5A; // arbitrary
	localparam logic [7:0] TYP = 8'h31; // arbitrary
	localparam logic [7:0] CAP = 8'h42; // arbitrary
	localparam logic [7:0] DEV = 8'h6C; // arbitrary
	localparam sfc_word_type ALL = 32'hFFFF_FFFF;
	logic           hclk;
	logic           hresetn;
	logic           rst_n;
	logic           hsel;
	logic           hwrite;
	logic           hreadyout;
	logic           hresp;
	logic           rd_ph;
	logic           armed;
	logic           wp;
	logic [31:0]    haddr;
	logic [31:0]    d;
	logic [1:0]     htrans;
	logic [2:0]     hsize;
	sfc_word_type   hwdata;
	sfc_word_type   hrdata;
	sfc_word_type   rd;
	sfc_word_type   ex_w;
	sfc_word_type   mk_w;
	sfc_status_type status;
	sfc_status_type st;
	int             fails;
	int             total_checks;
	int             seed;
	sfc_word_type   rd_q[$];
	sfc_word_type   mk_q[$];
	sfc_status_type st_q[$];

	sfc_link_if link ();
	sfc_host u_sfc_host (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hrdata(hrdata), .hresp(hresp), .link(link));
	sfc_dev #(.MFR_ID(MFR), .TYPE_ID(TYP), .CAP_ID(CAP), .DEV_ID(DEV)) u_sfc_dev (.link(link),
		.rst_n(rst_n), .status(status));
	sfc_link_asserts #(.MFR_ID(MFR)) u_sfc_link_asserts (.hclk(hclk), .hresetn(hresetn), .rst_n(rst_n),
		.sck(link.sck), .cs_n(link.cs_n), .si(link.si), .so_oe_n(link.so_oe_n), .wp_n(link.wp_n),
		.so_line(link.so_line), .status(status));

	initial
	begin
		hclk = 1'b0;
		forever #2 hclk = ~hclk;
	end

	task results();
	begin
		if (fails == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	end
	endtask

	task chk_rd(input sfc_word_type got, input sfc_word_type ex);
	begin
		total_checks++;
		if (got !== ex)
		begin
			fails++;
			$display("Error at %0t ns: read %h expected %h", $time, got, ex);
		end
	end
	endtask

	task chk_st(input sfc_status_type got, input sfc_status_type ex);
	begin
		total_checks++;
		if (got !== ex)
		begin
			fails++;
			$display("Error at %0t ns: status %h expected %h", $time, got, ex);
		end
	end
	endtask

	// bounded wait for hready sampled high
	task wait_ready();
		int n;
	begin
		n = 0;
		do
		begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 50);
		if (hreadyout !== 1'b1)
		begin
			fails++;
			results();
		end
	end
	endtask

	task ahb(input logic wr, input logic [7:0] a, input sfc_word_type wd, input sfc_word_type ex,
		input sfc_word_type mk);
	begin
		hsel <= 1'b1;
		haddr <= {24'h00_0000, a};
		htrans <= 2'b10;
		hwrite <= wr;
		wait_ready();
		htrans <= 2'b00;
		hwdata <= wd;
		rd_q.push_back(ex);
		mk_q.push_back(wr ? '0 : mk);
		wait_ready();
		rd = hrdata;
	end
	endtask

	// one framed command; status model kept alongside
	task run(input logic [7:0] op, input logic [23:0] arg, input logic [2:0] txn, input logic [2:0] rxn,
		input sfc_word_type ex);
		int n;
	begin
		if (op == 8'h06)
			st[1] = 1'b1;
		if (op == 8'hAD && st[1])
			st[6] = 1'b1;
		if (op == 8'h04)
			st[6] = 1'b0;
		if (op == 8'h01 && (armed || st[1]) && !(!wp && st[7]))
			st[7:2] = {arg[23], st[6], arg[21:18]};
		if (op == 8'h01 || op == 8'h04)
			st[1] = 1'b0;
		armed = (op == 8'h50);
		st_q.push_back(st);
		ahb(1'b1, 8'h00, {op, arg}, '0, '0);
		ahb(1'b1, 8'h04, {25'h000_0000, rxn, 1'b0, txn}, '0, '0);
		n = 0;
		do
		begin
			ahb(1'b0, 8'h08, '0, '0, '0);
			n++;
		end while (rd[0] !== 1'b0 && n < 200);
		if (rd[0] !== 1'b0)
		begin
			fails++;
			results();
		end
		if (rxn != 3'b000)
			ahb(1'b0, 8'h0C, '0, ex, ALL >> (8 * (4 - rxn)));
	end
	endtask

	function automatic sfc_word_type idw(input logic [7:0] op, input logic start, input int cnt);
		sfc_word_type w;
		logic [7:0] b;
		w = '0;
		for (int i = 0; i < cnt; i++)
		begin
			if (op == 8'h9F)
				b = (i % 3 == 0) ? MFR : ((i % 3 == 1) ? TYP : CAP);
			else
				b = ((i % 2 == 1) ^ start) ? DEV : MFR;
			w = {w[23:0], b};
		end
		return w;
	endfunction

	always @(posedge hclk)
	begin
		if (rd_ph && hreadyout === 1'b1)
		begin
			ex_w = rd_q.pop_front();
			mk_w = mk_q.pop_front();
			if (mk_w != '0)
				chk_rd(hrdata & mk_w, ex_w & mk_w);
		end
		if (hreadyout === 1'b1)
			rd_ph = hsel && htrans[1];
	end

	always @(posedge link.cs_n)
	begin
		if (hresetn === 1'b1 && st_q.size() != 0)
		begin
			#1;
			chk_st(status, st_q.pop_front());
		end
	end

	initial
	begin
		seed = 32'h0000_A42E;
		fails = 0;
		total_checks = 0;
		rd_ph = 1'b0;
		hsel <= 1'b0;
		haddr <= '0;
		htrans <= 2'b00;
		hwrite <= 1'b0;
		hsize <= 3'b010;
		hwdata <= '0;
		hresetn <= 1'b0;
		rst_n <= 1'b0;
		st = 8'h3C;
		armed = 1'b0;
		wp = 1'b1;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		rst_n <= 1'b1;
		@(posedge hclk);
		ahb(1'b0, 8'h10, '0, 32'h0000_0001, ALL);
		ahb(1'b0, 8'h14, '0, '0, ALL);
		run(8'hAD, '0, 3'd4, 3'd2, 32'h0000_FFFF);
		run(8'h06, '0, 3'd1, 3'd0, '0);
		run(8'hAD, '0, 3'd4, 3'd2, 32'h0000_FFFF);
		run(8'h04, '0, 3'd1, 3'd0, '0);
		d = $random(seed);
		run(8'h01, {d[7:0], 16'h0000}, 3'd2, 3'd0, '0);
		run(8'h50, '0, 3'd1, 3'd0, '0);
		run(8'h01, {1'b0, d[6:0], 16'h0000}, 3'd2, 3'd0, '0);
		d = $random(seed);
		run(8'h06, '0, 3'd1, 3'd0, '0);
		run(8'h01, {1'b0, d[6:0], 16'h0000}, 3'd2, 3'd0, '0);
		run(8'h50, '0, 3'd1, 3'd0, '0);
		run(8'h04, '0, 3'd1, 3'd0, '0);
		run(8'h01, {~d[7:0], 16'h0000}, 3'd2, 3'd0, '0);
		ahb(1'b1, 8'h10, '0, '0, '0);
		wp = 1'b0;
		ahb(1'b0, 8'h10, '0, '0, ALL);
		run(8'h50, '0, 3'd1, 3'd0, '0);
		run(8'h01, {1'b1, d[6:0], 16'h0000}, 3'd2, 3'd0, '0);
		run(8'h50, '0, 3'd1, 3'd0, '0);
		run(8'h01, {1'b0, ~d[6:0], 16'h0000}, 3'd2, 3'd0, '0);
		ahb(1'b1, 8'h10, 32'h0000_0001, '0, '0);
		wp = 1'b1;
		run(8'h50, '0, 3'd1, 3'd0, '0);
		run(8'h01, {1'b0, ~d[6:0], 16'h0000}, 3'd2, 3'd0, '0);
		run(8'h9F, '0, 3'd1, 3'd4, idw(8'h9F, 1'b0, 4));
		run(8'h9F, '0, 3'd1, 3'd1, idw(8'h9F, 1'b0, 1));
		run(8'h9F, '0, 3'd1, 3'd3, idw(8'h9F, 1'b0, 3));
		for (int i = 0; i < 4; i++)
		begin
			d[7:0] = (i > 1) ? 8'hAB : 8'h90;
			run(d[7:0], {23'h00_0000, i[0]}, 3'd4, 3'd3, idw(d[7:0], i[0], 3));
		end
		results();
	end
endmodule // test_spi_flash_write_enable_cmd_status_id_cmds
